/* logic/ucc_pkg.sv */
// constants and types shared by the device end and the driver end
// assumes one 25 MHz clock and word-wide register port on both ends
package ucc_pkg;
	localparam int ADDR_W = 12;
	localparam logic [11:0] DCFG_OFS = 12'h800;
	localparam logic [11:0] DCTL_OFS = 12'h804;
	localparam logic [11:0] IRQ_STAT_OFS = 12'h840;
	localparam logic [11:0] IRQ_MASK_OFS = 12'h844;
	localparam logic [31:0] DCFG_RST = 32'h0000_0000;
	localparam logic [31:0] DCTL_RST = 32'h0000_0000;
	localparam logic [31:0] DCFG_USED = 32'h0000_1ff7;
	// configuration fields
	localparam int CFG_PFE_LSB = 11;
	localparam int CFG_ADDR_LSB = 4;
	localparam int CFG_NZ_BIT = 2;
	localparam int CFG_DS_LSB = 0;
	localparam logic [1:0] SPEED_FULL = 2'h3;
	// control fields
	localparam int CTL_INIT_BIT = 11;
	localparam int CTL_CLR_OUT = 10;
	localparam int CTL_SET_OUT = 9;
	localparam int CTL_CLR_IN = 8;
	localparam int CTL_SET_IN = 7;
	localparam int CTL_OUT_ST = 3;
	localparam int CTL_IN_ST = 2;
	localparam int CTL_SD = 1;
	// interrupt status / mask fields
	localparam int IRQ_W = 3;
	localparam int IRQ_PFE = 0;
	localparam int IRQ_IN_EFF = 1;
	localparam int IRQ_OUT_EFF = 2;
	localparam logic [2:0] IRQ_RST = 3'h0;
	// frame timing
	localparam int CLK_MHZ = 25;
	localparam int FRAME_TIME_US = 1000;
	localparam int FRAME_CYCLES = FRAME_TIME_US * CLK_MHZ;
	localparam int FCNT_W = 16;

	typedef enum logic [1:0] {UCC_TOK_OUT, UCC_TOK_IN, UCC_TOK_SETUP} ucc_tok_e;
	typedef enum logic [1:0] {UCC_RSP_NONE, UCC_RSP_ACK, UCC_RSP_NAK,
		UCC_RSP_STALL} ucc_resp_e;
	typedef enum logic [3:0] {UCC_CMD_SET_CFG, UCC_CMD_SET_ADDR,
		UCC_CMD_INIT_DONE, UCC_CMD_SET_OUT_NAK, UCC_CMD_CLR_OUT_NAK,
		UCC_CMD_SET_IN_NAK, UCC_CMD_CLR_IN_NAK, UCC_CMD_DISCONNECT,
		UCC_CMD_CONNECT, UCC_CMD_WR_MASK, UCC_CMD_CLR_IRQ,
		UCC_CMD_READ} ucc_cmd_e;

	// cycle in the frame where the end-of-periodic flag fires
	function automatic logic [15:0] ucc_pfe_point(input logic [1:0] code,
		input int frame);
		int pct;
		pct = 80 + 5 * int'(code);
		return 16'((frame * pct) / 100);
	endfunction
endpackage

/* logic/ucc_if.sv */
// register port joining the driver end and the configuration/control end
// assumes both ends share clk and rst_n
`timescale 1ns/1ps
interface ucc_if;
	logic [11:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	logic irq;
	modport dev (input addr, input wdata, input wr, input rd,
		output rdata, output irq);
	modport drv (output addr, output wdata, output wr, output rd,
		input rdata, input irq);
endinterface

/* logic/ucc_dev.sv */
// device-mode configuration and control registers of a full-speed core
// assumes token fields come decoded from packet logic on the same clock
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
// Summary of operation
// - frame end flag at 80/85/90/95 percent
// - accept only tokens matching device address
// - software sets address after set address
// - policy set: nonzero status out stalled, dropped
// - policy clear: endpoint nak/stall decide
// - speed field, only code 11 defined
// - software leaves configuration alone after init; a wake unlocks the driver and its own sign-off does not lock it again
// - software sets init-done bit after wake
// - bit 10 clears all-out nak state
// - bit 9 sets state, flags effective later
// - software clears effective flag before setting
// - bit 8 clears all-in nak state
module ucc_dev import ucc_pkg::*; #(
	parameter int FRAME_LEN = FRAME_CYCLES
) (
	input wire logic clk, // 25 MHz
	input wire logic rst_n, // async, active low
	ucc_if.dev bus, // register port
	input wire logic sof, // start of frame seen, pulse
	input wire logic wake, // left power-down, pulse
	input wire logic tok_valid, // token received, pulse
	input wire ucc_tok_e tok_kind, // token kind
	input wire logic [6:0] tok_addr, // token address field
	input wire logic status_out, // out is a status stage
	input wire logic data_nonzero, // out data length above zero
	input wire logic ep_nak, // endpoint nak state
	input wire logic ep_stall, // endpoint stall
	input wire logic fifo_ok, // fifo room or data present
	output logic resp_valid, // handshake decided, pulse
	output ucc_resp_e resp_code, // handshake to send
	output logic resp_store, // keep the out data
	output logic periodic_frame_end_flag, // frame end point, pulse
	output logic pullup_en, // attach pull-up
	output logic full_speed, // speed field holds full speed
	output logic init_after_wake_done // core may resume
);
	logic [31:0] cfg, next_cfg;
	logic init_done, next_init_done;
	logic out_st, next_out_st;
	logic in_st, next_in_st;
	logic sd, next_sd;
	logic out_pend, next_out_pend;
	logic in_pend, next_in_pend;
	logic [2:0] stat, next_stat;
	logic [2:0] mask, next_mask;
	logic [15:0] fcnt, next_fcnt;
	logic fired, next_fired;
	logic [31:0] rdata, next_rdata;
	logic irq, next_irq;
	logic next_resp_valid, next_resp_store, next_pfe, next_pullup, next_fs;
	ucc_resp_e next_resp;

	logic wr_cfg, wr_ctl, wr_stat, wr_mask;
	logic [2:0] ev;
	logic [31:0] ctl_view;

	assign bus.rdata = rdata;
	assign bus.irq = irq;
	assign init_after_wake_done = init_done;

	always_comb begin
		wr_cfg = bus.wr && bus.addr == DCFG_OFS;
		wr_ctl = bus.wr && bus.addr == DCTL_OFS;
		wr_stat = bus.wr && bus.addr == IRQ_STAT_OFS;
		wr_mask = bus.wr && bus.addr == IRQ_MASK_OFS;
		ev = IRQ_RST;
		ctl_view = 32'h0000_0000;
		ctl_view[CTL_INIT_BIT] = init_done;
		ctl_view[CTL_OUT_ST] = out_st;
		ctl_view[CTL_IN_ST] = in_st;
		ctl_view[CTL_SD] = sd;

		next_cfg = wr_cfg ? (bus.wdata & DCFG_USED) : cfg;
		next_mask = wr_mask ? bus.wdata[2:0] : mask;
		next_init_done = init_done;
		next_sd = sd;
		next_out_st = out_st;
		next_in_st = in_st;
		next_out_pend = out_pend;
		next_in_pend = in_pend;
		// a wake drops readiness until software signs off again
		if (wake)
			next_init_done = 1'b0;
		if (wr_ctl) begin
			next_init_done = bus.wdata[CTL_INIT_BIT];
			next_sd = bus.wdata[CTL_SD];
			if (bus.wdata[CTL_CLR_OUT])
				next_out_st = 1'b0;
			if (bus.wdata[CTL_SET_OUT]) begin
				next_out_st = 1'b1;
				if (!out_st)
					next_out_pend = 1'b1;
			end
			if (bus.wdata[CTL_CLR_IN])
				next_in_st = 1'b0;
			if (bus.wdata[CTL_SET_IN]) begin
				next_in_st = 1'b1;
				if (!in_st)
					next_in_pend = 1'b1;
			end
		end
		// effective only once no transaction is being decided
		if (out_pend && !tok_valid) begin
			ev[IRQ_OUT_EFF] = 1'b1;
			next_out_pend = 1'b0;
		end
		if (in_pend && !tok_valid) begin
			ev[IRQ_IN_EFF] = 1'b1;
			next_in_pend = 1'b0;
		end

		// frame position, restarted by every start of frame
		next_fcnt = fcnt;
		next_fired = fired;
		next_pfe = 1'b0;
		if (sof) begin
			next_fcnt = 16'h0000;
			next_fired = 1'b0;
		end else begin
			if (fcnt != 16'hffff)
				next_fcnt = fcnt + 16'h0001;
			if (!fired && fcnt == ucc_pfe_point(cfg[CFG_PFE_LSB +: 2],
				FRAME_LEN)) begin
				next_pfe = 1'b1;
				ev[IRQ_PFE] = 1'b1;
				next_fired = 1'b1;
			end
		end

		// set wins over a one written to clear
		next_stat = stat & ~(wr_stat ? bus.wdata[2:0] : 3'h0);
		next_stat = next_stat | ev;
		next_irq = |(next_stat & next_mask);

		next_rdata = 32'h0000_0000;
		if (bus.rd) begin
			case (bus.addr)
				DCFG_OFS: next_rdata = cfg;
				DCTL_OFS: next_rdata = ctl_view;
				IRQ_STAT_OFS: next_rdata = {29'h0000_0000, stat};
				IRQ_MASK_OFS: next_rdata = {29'h0000_0000, mask};
				default: next_rdata = 32'h0000_0000;
			endcase
		end

		// only full speed is defined; a reserved code keeps the pull-up off
		next_fs = cfg[CFG_DS_LSB +: 2] == SPEED_FULL;
		next_pullup = next_fs && !sd;

		next_resp_valid = 1'b0;
		next_resp = UCC_RSP_NONE;
		next_resp_store = 1'b0;
		if (tok_valid && !sd && tok_addr == cfg[CFG_ADDR_LSB +: 7]) begin
			next_resp_valid = 1'b1;
			if (tok_kind == UCC_TOK_IN) begin
				if (in_st)
					next_resp = UCC_RSP_NAK;
				else if (ep_stall)
					next_resp = UCC_RSP_STALL;
				else if (ep_nak || !fifo_ok)
					next_resp = UCC_RSP_NAK;
				else
					next_resp = UCC_RSP_ACK;
			end else if (tok_kind == UCC_TOK_SETUP) begin
				next_resp = fifo_ok ? UCC_RSP_ACK : UCC_RSP_NONE;
				next_resp_store = fifo_ok;
			end else if (out_st) begin
				next_resp = UCC_RSP_NAK;
			end else if (status_out && data_nonzero && cfg[CFG_NZ_BIT]) begin
				next_resp = UCC_RSP_STALL;
			end else if (ep_stall) begin
				next_resp = UCC_RSP_STALL;
			end else if (ep_nak || !fifo_ok) begin
				next_resp = UCC_RSP_NAK;
			end else begin
				next_resp = UCC_RSP_ACK;
				next_resp_store = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg <= DCFG_RST;
			init_done <= 1'b0;
			out_st <= 1'b0;
			in_st <= 1'b0;
			sd <= 1'b0;
			out_pend <= 1'b0;
			in_pend <= 1'b0;
			stat <= IRQ_RST;
			mask <= IRQ_RST;
			fcnt <= 16'h0000;
			fired <= 1'b1;
			rdata <= 32'h0000_0000;
			irq <= 1'b0;
			resp_valid <= 1'b0;
			resp_code <= UCC_RSP_NONE;
			resp_store <= 1'b0;
			periodic_frame_end_flag <= 1'b0;
			pullup_en <= 1'b0;
			full_speed <= 1'b0;
		end else begin
			cfg <= next_cfg;
			init_done <= next_init_done;
			out_st <= next_out_st;
			in_st <= next_in_st;
			sd <= next_sd;
			out_pend <= next_out_pend;
			in_pend <= next_in_pend;
			stat <= next_stat;
			mask <= next_mask;
			fcnt <= next_fcnt;
			fired <= next_fired;
			rdata <= next_rdata;
			irq <= next_irq;
			resp_valid <= next_resp_valid;
			resp_code <= next_resp;
			resp_store <= next_resp_store;
			periodic_frame_end_flag <= next_pfe;
			pullup_en <= next_pullup;
			full_speed <= next_fs;
		end
	end
endmodule

/* logic/ucc_drv.sv */
// driver end: turns software commands into register port cycles
// assumes the device end answers reads one cycle later, never stalls
`timescale 1ns/1ps
module ucc_drv import ucc_pkg::*; (
	input wire logic clk, // 25 MHz
	input wire logic rst_n, // async, active low
	ucc_if.drv bus, // register port
	input wire logic cmd_valid, // command offered
	input wire ucc_cmd_e cmd, // command code
	input wire logic [31:0] cmd_arg, // value, address or offset
	input wire logic addr_granted, // host already set the address
	input wire logic wake, // left power-down, pulse
	output logic cmd_ready, // command may be taken
	output logic cmd_refused, // command dropped, pulse
	output logic rsp_valid, // read data valid, pulse
	output logic [31:0] rsp_data, // read data
	output logic irq_seen // device interrupt level
);
	typedef enum logic [1:0] {ST_IDLE, ST_SECOND, ST_READ, ST_TAKE} ucc_st_e;
	ucc_st_e st, next_st;
	logic [31:0] cfg_sh, next_cfg_sh;
	logic [31:0] ctl_sh, next_ctl_sh;
	logic [31:0] wd2, next_wd2;
	logic locked, next_locked;
	logic [11:0] addr, next_addr;
	logic [31:0] wdata, next_wdata;
	logic wr, next_wr, rd, next_rd;
	logic next_ready, next_refused, next_rsp_valid;
	logic [31:0] next_rsp_data;

	assign bus.addr = addr;
	assign bus.wdata = wdata;
	assign bus.wr = wr;
	assign bus.rd = rd;

	always_comb begin
		next_st = st;
		next_cfg_sh = cfg_sh;
		next_ctl_sh = ctl_sh;
		next_wd2 = wd2;
		next_locked = locked;
		next_addr = addr;
		next_wdata = wdata;
		next_wr = 1'b0;
		next_rd = 1'b0;
		next_refused = 1'b0;
		next_rsp_valid = 1'b0;
		next_rsp_data = rsp_data;
		case (st)
			ST_IDLE: begin
				if (wake) begin
					// restore configuration, then sign off
					next_locked = 1'b0;
					next_addr = DCFG_OFS;
					next_wdata = cfg_sh;
					next_wr = 1'b1;
					next_ctl_sh[CTL_INIT_BIT] = 1'b1;
					next_wd2 = next_ctl_sh;
					next_st = ST_SECOND;
				end else if (cmd_valid) begin
					next_wr = 1'b1;
					next_addr = DCTL_OFS;
					case (cmd)
						UCC_CMD_SET_CFG, UCC_CMD_SET_ADDR: begin
							if (cmd == UCC_CMD_SET_ADDR) begin
								next_cfg_sh[CFG_ADDR_LSB +: 7] = cmd_arg[6:0];
							end else begin
								next_cfg_sh = cmd_arg & DCFG_USED;
								next_cfg_sh[CFG_ADDR_LSB +: 7] =
									cfg_sh[CFG_ADDR_LSB +: 7];
							end
							if (locked || (cmd == UCC_CMD_SET_ADDR &&
								!addr_granted)) begin
								next_cfg_sh = cfg_sh;
								next_wr = 1'b0;
								next_refused = 1'b1;
							end else begin
								next_addr = DCFG_OFS;
								next_wdata = next_cfg_sh;
							end
						end
						UCC_CMD_INIT_DONE: begin
							next_ctl_sh[CTL_INIT_BIT] = 1'b1;
							next_wdata = next_ctl_sh;
							next_locked = 1'b1;
						end
						UCC_CMD_SET_OUT_NAK, UCC_CMD_SET_IN_NAK: begin
							// stale effective flag is cleared first
							next_addr = IRQ_STAT_OFS;
							next_wdata = 32'h0000_0000;
							next_wd2 = ctl_sh;
							if (cmd == UCC_CMD_SET_OUT_NAK) begin
								next_wdata[IRQ_OUT_EFF] = 1'b1;
								next_wd2[CTL_SET_OUT] = 1'b1;
							end else begin
								next_wdata[IRQ_IN_EFF] = 1'b1;
								next_wd2[CTL_SET_IN] = 1'b1;
							end
							next_st = ST_SECOND;
						end
						UCC_CMD_CLR_OUT_NAK: begin
							next_wdata = ctl_sh;
							next_wdata[CTL_CLR_OUT] = 1'b1;
						end
						UCC_CMD_CLR_IN_NAK: begin
							next_wdata = ctl_sh;
							next_wdata[CTL_CLR_IN] = 1'b1;
						end
						UCC_CMD_DISCONNECT, UCC_CMD_CONNECT: begin
							next_ctl_sh[CTL_SD] = cmd == UCC_CMD_DISCONNECT;
							next_wdata = next_ctl_sh;
						end
						UCC_CMD_WR_MASK: begin
							next_addr = IRQ_MASK_OFS;
							next_wdata = cmd_arg;
						end
						UCC_CMD_CLR_IRQ: begin
							next_addr = IRQ_STAT_OFS;
							next_wdata = cmd_arg;
						end
						UCC_CMD_READ: begin
							next_wr = 1'b0;
							next_rd = 1'b1;
							next_addr = cmd_arg[11:0];
							next_st = ST_READ;
						end
						default: begin
							next_wr = 1'b0;
							next_refused = 1'b1;
						end
					endcase
				end
			end
			ST_SECOND: begin
				next_addr = DCTL_OFS;
				next_wdata = wd2;
				next_wr = 1'b1;
				next_st = ST_IDLE;
			end
			ST_READ: begin
				// strobe cycle; the answer stands only in the next one
				next_st = ST_TAKE;
			end
			ST_TAKE: begin
				next_rsp_valid = 1'b1;
				next_rsp_data = bus.rdata;
				next_st = ST_IDLE;
			end
			default: next_st = ST_IDLE;
		endcase
		next_ready = next_st == ST_IDLE;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= ST_IDLE;
			cfg_sh <= DCFG_RST;
			ctl_sh <= DCTL_RST;
			wd2 <= 32'h0000_0000;
			locked <= 1'b0;
			addr <= 12'h000;
			wdata <= 32'h0000_0000;
			wr <= 1'b0;
			rd <= 1'b0;
			cmd_ready <= 1'b0;
			cmd_refused <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= 32'h0000_0000;
			irq_seen <= 1'b0;
		end else begin
			st <= next_st;
			cfg_sh <= next_cfg_sh;
			ctl_sh <= next_ctl_sh;
			wd2 <= next_wd2;
			locked <= next_locked;
			addr <= next_addr;
			wdata <= next_wdata;
			wr <= next_wr;
			rd <= next_rd;
			cmd_ready <= next_ready;
			cmd_refused <= next_refused;
			rsp_valid <= next_rsp_valid;
			rsp_data <= next_rsp_data;
			irq_seen <= bus.irq;
		end
	end
endmodule

/* bench/ucc_assertions.sv */
// checker for the register port between driver end and device end
// assumes it sees the interface signals plus the shared clk and rst_n
`timescale 1ns/1ps
module ucc_assertions import ucc_pkg::*; (
	input wire logic clk, // 25 MHz
	input wire logic rst_n, // async, active low
	input wire logic [11:0] addr, // byte offset
	input wire logic [31:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	input wire logic [31:0] rdata, // read data
	input wire logic irq // interrupt level
);
	logic sh_out, sh_in, sh_sd, rd_ctl, rd_cfg, rd_unm;
	logic [31:0] sh_cfg;
	logic unm;
	assign unm = addr != DCFG_OFS && addr != DCTL_OFS &&
		addr != IRQ_STAT_OFS && addr != IRQ_MASK_OFS;
	// shadow of what the written words must leave in the device
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sh_out <= 1'b0;
			sh_in <= 1'b0;
			sh_sd <= 1'b0;
			sh_cfg <= DCFG_RST;
		end else if (wr && addr == DCTL_OFS) begin
			sh_out <= wdata[CTL_SET_OUT] | (sh_out & !wdata[CTL_CLR_OUT]);
			sh_in <= wdata[CTL_SET_IN] | (sh_in & !wdata[CTL_CLR_IN]);
			sh_sd <= wdata[CTL_SD];
		end else if (wr && addr == DCFG_OFS) begin
			sh_cfg <= wdata & DCFG_USED;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_ctl <= 1'b0;
			rd_cfg <= 1'b0;
			rd_unm <= 1'b0;
		end else begin
			rd_ctl <= rd && addr == DCTL_OFS;
			rd_cfg <= rd && addr == DCFG_OFS;
			rd_unm <= rd && unm;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
		else $error("read data not zero outside an answer");
	cfg_readback_a: assert property (
		rd_cfg |-> rdata == $past(sh_cfg))
		else $error("configuration reads back wrong");
	out_state_a: assert property (
		rd_ctl |-> rdata[CTL_OUT_ST] == $past(sh_out))
		else $error("out nak state reads wrong");
	in_state_a: assert property (
		rd_ctl |-> rdata[CTL_IN_ST] == $past(sh_in))
		else $error("in nak state reads wrong");
	action_zero_a: assert property (
		rd_ctl |-> rdata[10:7] == 4'h0)
		else $error("action bits do not read zero");
	sd_state_a: assert property (
		rd_ctl |-> rdata[CTL_SD] == $past(sh_sd))
		else $error("disconnect bit reads wrong");
	unmapped_zero_a: assert property (rd_unm |-> rdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	irq_masked_a: assert property (
		wr && addr == IRQ_MASK_OFS && wdata[2:0] == 3'h0
		##1 !(wr && addr == IRQ_MASK_OFS) |=> !irq)
		else $error("interrupt high with all masked");
	out_clear_first_a: assert property (
		wr && addr == DCTL_OFS && wdata[CTL_SET_OUT] |-> $past(wr) &&
		$past(addr) == IRQ_STAT_OFS && $past(wdata[IRQ_OUT_EFF]))
		else $error("out nak set without clearing its flag");
	in_clear_first_a: assert property (
		wr && addr == DCTL_OFS && wdata[CTL_SET_IN] |-> $past(wr) &&
		$past(addr) == IRQ_STAT_OFS && $past(wdata[IRQ_IN_EFF]))
		else $error("in nak set without clearing its flag");
	cover property (wr && addr == DCTL_OFS && wdata[CTL_SET_OUT]);
	cover property (rd_unm);
	cover property (irq);
endmodule

/* bench/tb.sv */
// testbench: driver end and device end joined over the register port
// assumes the frame length is shortened to 200 cycles
`timescale 1ns/1ps
module tb import ucc_pkg::*; ();
	localparam int FLEN = 200;
	logic clk, rst_n, sof, wake, tok_valid, status_out, data_nonzero;
	logic ep_nak, ep_stall, fifo_ok, cmd_valid, addr_granted;
	logic resp_valid, resp_store, periodic_frame_end_flag, pullup_en;
	logic full_speed, init_after_wake_done, cmd_ready, cmd_refused;
	logic rsp_valid, irq_seen;
	logic [6:0] tok_addr;
	logic [31:0] cmd_arg, rsp_data;
	ucc_tok_e tok_kind;
	ucc_resp_e resp_code;
	ucc_cmd_e cmd;
	int n_fail, checks_done, n_ref, n_rsp;
	ucc_if u_ucc_if();
	ucc_dev #(.FRAME_LEN(FLEN)) u_ucc_dev (.clk(clk), .rst_n(rst_n),
		.bus(u_ucc_if.dev), .sof(sof), .wake(wake), .tok_valid(tok_valid),
		.tok_kind(tok_kind), .tok_addr(tok_addr), .status_out(status_out),
		.data_nonzero(data_nonzero), .ep_nak(ep_nak), .ep_stall(ep_stall),
		.fifo_ok(fifo_ok), .resp_valid(resp_valid), .resp_code(resp_code),
		.resp_store(resp_store),
		.periodic_frame_end_flag(periodic_frame_end_flag),
		.pullup_en(pullup_en), .full_speed(full_speed),
		.init_after_wake_done(init_after_wake_done));
	ucc_drv u_ucc_drv (.clk(clk), .rst_n(rst_n), .bus(u_ucc_if.drv),
		.cmd_valid(cmd_valid), .cmd(cmd), .cmd_arg(cmd_arg),
		.addr_granted(addr_granted), .wake(wake), .cmd_ready(cmd_ready),
		.cmd_refused(cmd_refused), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .irq_seen(irq_seen));
	ucc_assertions u_ucc_assertions (.clk(clk), .rst_n(rst_n),
		.addr(u_ucc_if.addr), .wdata(u_ucc_if.wdata), .wr(u_ucc_if.wr),
		.rd(u_ucc_if.rd), .rdata(u_ucc_if.rdata), .irq(u_ucc_if.irq));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		if (cmd_refused === 1'b1) n_ref++;
		if (rsp_valid === 1'b1) n_rsp++;
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wait_ready;
		int n;
		n = 0;
		@(negedge clk);
		while (cmd_ready !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		if (cmd_ready !== 1'b1) begin
			n_fail++;
			tally_and_finish();
		end
	endtask
	task automatic issue(input ucc_cmd_e c, input logic [31:0] a);
		wait_ready();
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd <= c;
		cmd_arg <= a;
		@(posedge clk);
		cmd_valid <= 1'b0;
		wait_ready();
	endtask
	task automatic rchk(input logic [11:0] o, input logic [31:0] m,
		input logic [31:0] e);
		int n, c0;
		c0 = n_rsp;
		issue(UCC_CMD_READ, {20'h0_0000, o});
		n = 0;
		while (n_rsp == c0 && n < 20) begin
			@(negedge clk);
			n++;
		end
		if (n_rsp == c0) begin
			n_fail++;
			tally_and_finish();
		end
		chk("read data", e, rsp_data & m);
	endtask
	// f: status_out nonzero ep_nak ep_stall fifo_ok; e: valid store code
	task automatic tok(input ucc_tok_e k, input logic [6:0] a,
		input logic [4:0] f, input logic [3:0] e);
		@(posedge clk);
		tok_valid <= 1'b1;
		tok_kind <= k;
		tok_addr <= a;
		{status_out, data_nonzero, ep_nak, ep_stall, fifo_ok} <= f;
		@(posedge clk);
		tok_valid <= 1'b0;
		@(negedge clk);
		chk("resp_valid", {31'h0, e[3]}, {31'h0, resp_valid});
		if (e[3]) chk("resp_code", {30'h0, e[1:0]}, resp_code);
		if (e[3] && k != UCC_TOK_IN) chk("resp_store", e[2], resp_store);
	endtask
	task automatic t_regs;
		rchk(DCFG_OFS, 32'hffff_ffff, DCFG_RST);
		rchk(DCTL_OFS, 32'hffff_ffff, DCTL_RST);
		rchk(IRQ_STAT_OFS, 32'hffff_ffff, 32'h0000_0000);
		rchk(IRQ_MASK_OFS, 32'hffff_ffff, 32'h0000_0000);
		rchk(12'h808, 32'hffff_ffff, 32'h0000_0000);
		issue(UCC_CMD_SET_ADDR, 32'h0000_005a);
		cyc(2);
		chk("refusals", 1, n_ref);
		rchk(DCFG_OFS, 32'hffff_ffff, 32'h0000_0000);
		addr_granted <= 1'b1;
		issue(UCC_CMD_SET_ADDR, 32'h0000_005a);
		issue(UCC_CMD_SET_CFG, 32'h0000_0801);
		rchk(DCFG_OFS, 32'hffff_ffff, 32'h0000_0da1);
		chk("full_speed", 0, full_speed);
		chk("pullup_en", 0, pullup_en);
		issue(UCC_CMD_SET_CFG, 32'h0000_0007);
		cyc(4);
		chk("full_speed", 1, full_speed);
		chk("pullup_en", 1, pullup_en);
		$display("registers test done");
	endtask
	task automatic t_tokens;
		tok(UCC_TOK_IN, 7'h5b, 5'b00001, 4'h0);
		tok(UCC_TOK_IN, 7'h5a, 5'b00001, 4'h9);
		tok(UCC_TOK_IN, 7'h5a, 5'b00000, 4'ha);
		tok(UCC_TOK_OUT, 7'h5a, 5'b11001, 4'hb);
		issue(UCC_CMD_SET_CFG, 32'h0000_0003);
		tok(UCC_TOK_OUT, 7'h5a, 5'b11101, 4'ha);
		tok(UCC_TOK_OUT, 7'h5a, 5'b11011, 4'hb);
		tok(UCC_TOK_OUT, 7'h5a, 5'b11001, 4'hd);
		issue(UCC_CMD_SET_OUT_NAK, 32'h0);
		tok(UCC_TOK_OUT, 7'h5a, 5'b00001, 4'ha);
		tok(UCC_TOK_IN, 7'h5a, 5'b00001, 4'h9);
		rchk(DCTL_OFS, 32'h0000_0008, 32'h0000_0008);
		rchk(IRQ_STAT_OFS, 32'h0000_0004, 32'h0000_0004);
		issue(UCC_CMD_SET_OUT_NAK, 32'h0);
		rchk(IRQ_STAT_OFS, 32'h0000_0004, 32'h0000_0000);
		issue(UCC_CMD_CLR_OUT_NAK, 32'h0);
		rchk(DCTL_OFS, 32'h0000_0008, 32'h0000_0000);
		tok(UCC_TOK_OUT, 7'h5a, 5'b00001, 4'hd);
		issue(UCC_CMD_SET_IN_NAK, 32'h0);
		tok(UCC_TOK_IN, 7'h5a, 5'b00001, 4'ha);
		rchk(IRQ_STAT_OFS, 32'h0000_0002, 32'h0000_0002);
		issue(UCC_CMD_CLR_IN_NAK, 32'h0);
		rchk(DCTL_OFS, 32'h0000_0004, 32'h0000_0000);
		tok(UCC_TOK_IN, 7'h5a, 5'b00001, 4'h9);
		issue(UCC_CMD_DISCONNECT, 32'h0);
		cyc(4);
		chk("pullup_en", 0, pullup_en);
		tok(UCC_TOK_IN, 7'h5a, 5'b00001, 4'h0);
		issue(UCC_CMD_CONNECT, 32'h0);
		cyc(4);
		chk("pullup_en", 1, pullup_en);
		tok(UCC_TOK_SETUP, 7'h5a, 5'b00001, 4'hd);
		$display("tokens test done");
	endtask
	task automatic t_frame;
		int k, n;
		for (int c = 0; c < 4; c++) begin
			issue(UCC_CMD_SET_CFG, {19'h0, c[1:0], 11'h003});
			n = FLEN * (80 + 5 * c) / 100;
			@(posedge clk);
			sof <= 1'b1;
			@(posedge clk);
			sof <= 1'b0;
			k = 0;
			while (periodic_frame_end_flag !== 1'b1 && k < 300) begin
				@(negedge clk);
				k++;
			end
			if (periodic_frame_end_flag !== 1'b1) begin
				n_fail++;
				tally_and_finish();
			end
			// one cycle for the start of frame to restart the counter, one for the registered flag
			chk("frame end delay", n + 2, k);
			if (c == 0) begin
				cyc(8);
				chk("irq_seen", 0, irq_seen);
				rchk(IRQ_STAT_OFS, 32'h0000_0001, 32'h0000_0001);
				issue(UCC_CMD_WR_MASK, 32'h0000_0001);
				cyc(8);
				chk("irq_seen", 1, irq_seen);
				issue(UCC_CMD_CLR_IRQ, 32'h0000_0001);
				cyc(8);
				chk("irq_seen", 0, irq_seen);
				issue(UCC_CMD_WR_MASK, 32'h0000_0000);
			end
		end
		$display("frame test done");
	endtask
	task automatic t_init;
		issue(UCC_CMD_INIT_DONE, 32'h0);
		cyc(4);
		chk("init done", 1, init_after_wake_done);
		issue(UCC_CMD_SET_CFG, 32'h0000_0003);
		cyc(2);
		chk("refusals", 2, n_ref);
		rchk(DCFG_OFS, 32'hffff_ffff, 32'h0000_1da3);
		@(posedge clk);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		cyc(1);
		chk("init done", 0, init_after_wake_done);
		cyc(11);
		chk("init done", 1, init_after_wake_done);
		rchk(DCFG_OFS, 32'hffff_ffff, 32'h0000_1da3);
		tok(UCC_TOK_IN, 7'h5a, 5'b00001, 4'h9);
		$display("init test done");
	endtask
	initial begin
		{rst_n, sof, wake, tok_valid, status_out, data_nonzero} = 6'h0;
		{ep_nak, ep_stall, fifo_ok, cmd_valid, addr_granted} = 5'h0;
		tok_addr = 7'h00;
		tok_kind = UCC_TOK_OUT;
		cmd = UCC_CMD_READ;
		cmd_arg = 32'h0000_0000;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_tokens();
		t_frame();
		t_init();
		tally_and_finish();
	end
endmodule
